// [rtl/host_bus_address_capture.sv]
// Host bus address capture and cycle framing front end.
// Functional notes
// RL1 - Separate mode: latch address on select fall.
// RL2 - Addresses select words; lowest pin is bit 2.
// RL3 - Mux mode: bit-2 pin is address latch strobe.
// RL4 - Mux mode ignores bit-3 and bit-5 pins.
// RL5 - Select rise ends the current cycle.
// RL6 - Three interrupt outputs, each any event mix.
// RL7 - Wave outputs six, seven synced to time base.
// RL8 - Bits 3 and 5 sampled with others.
// RL9 - Strap caught at reset release; high means mux.
// RL10 - Host write enable low writes, high reads.
// RL11 - Data driven only while output enable low.
// RL12 - Host sets address before lowering select.
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_address_capture_map.svh"
module host_bus_address_capture
    import host_bus_address_capture_pkg::*;
#(
    parameter int AW = `HBA_ADDR_W,
    parameter int EW = `HBA_EVT_W,
    parameter int WW = `HBA_WAVE_W
) (
    input  wire logic          CLK_I,
    input  wire logic          RST_I,
    input  wire logic          BUS_MUX_STRAP_I,
    input  wire logic          CS_N_I,
    input  wire logic          WE_N_I,
    input  wire logic          OE_N_I,
    input  wire logic [AW-1:0] ADDR_LINES_I,
    input  wire logic [AW-1:0] MUX_ADDR_I,
    input  wire logic [EW-1:0] EVENTS_I,
    input  wire logic [EW-1:0] IRQ_SEL_ZERO_I,
    input  wire logic [EW-1:0] IRQ_SEL_ONE_I,
    input  wire logic [EW-1:0] IRQ_SEL_TWO_I,
    input  wire logic          TB_TICK_I,
    input  wire logic [WW-1:0] WAVE_HALF_SIX_I,
    input  wire logic [WW-1:0] WAVE_HALF_SEVEN_I,
    output logic [AW+1:0]      WORD_ADDR_O,
    output logic               ADDR_VALID_O,
    output logic               CYCLE_WRITE_O,
    output logic               CYCLE_END_O,
    output logic               DATA_OE_O,
    output logic               MUX_MODE_O,
    output logic               IRQ_OUT_ZERO_O,
    output logic               IRQ_OUT_ONE_O,
    output logic               IRQ_OUT_TWO_O,
    output logic               SYNC_WAVE_OUT_SIX_O,
    output logic               SYNC_WAVE_OUT_SEVEN_O
);
    // Two-stage synchronisers for all host pins; first stage read only by second.
    logic [AW+2:0] pin_s1_r, pin_s2_r;
    logic [AW-1:0] mux_s1_r, mux_s2_r;
    logic          cs_prev_r, ale_prev_r, rst_prev_r, strap_s1_r, strap_s2_r;
    logic          wave6, wave7;
    cycle_state_t  state_r, state_nxt;

    always_ff @(posedge CLK_I) begin
        pin_s1_r   <= {OE_N_I, WE_N_I, CS_N_I, ADDR_LINES_I};
        pin_s2_r   <= pin_s1_r;
        mux_s1_r   <= MUX_ADDR_I;
        mux_s2_r   <= mux_s1_r;
        strap_s1_r <= BUS_MUX_STRAP_I;
        strap_s2_r <= strap_s1_r;
    end

    // Named views of the synchronised pins.
    wire [AW-1:0] addr_s  = pin_s2_r[AW-1:0];
    wire          cs_n_s  = pin_s2_r[AW];
    wire          we_n_s  = pin_s2_r[AW+1];
    wire          oe_n_s  = pin_s2_r[AW+2];
    wire          ale_s   = addr_s[0];                           // [RL3]
    wire          cs_fall = cs_prev_r & ~cs_n_s;
    wire          cs_rise = ~cs_prev_r & cs_n_s;                 // [RL5]
    wire          ale_fall = ale_prev_r & ~ale_s;
    wire          rst_rel = rst_prev_r & ~RST_I;
    // Mux mode takes the address from the shared lines, so pins 3 and 5 never matter.
    wire [AW+1:0] sep_addr = {addr_s, 2'b00};                    // [RL2] [RL8]
    wire [AW+1:0] mux_addr = {mux_s2_r[AW-1:1], 1'b0, 2'b00} | {{(AW-1){1'b0}}, 3'b000}; // [RL4]

    function automatic logic irq_any(input logic [EW-1:0] ev, input logic [EW-1:0] sel);
        irq_any = |(ev & sel);
    endfunction : irq_any

    // Interrupt requests, each an OR of the events its select enables.
    wire          irq0_req = irq_any(EVENTS_I, IRQ_SEL_ZERO_I);  // [RL6]
    wire          irq1_req = irq_any(EVENTS_I, IRQ_SEL_ONE_I);
    wire          irq2_req = irq_any(EVENTS_I, IRQ_SEL_TWO_I);

    // Edge history and strap capture at reset release.
    always_ff @(posedge CLK_I) begin
        rst_prev_r <= RST_I;
        if (RST_I) begin
            cs_prev_r  <= 1'b1;
            ale_prev_r <= 1'b0;
        end else begin
            cs_prev_r  <= cs_n_s;
            ale_prev_r <= ale_s;
        end
        if (RST_I) begin
            MUX_MODE_O <= `HBA_MUX_RST;
        end else if (rst_rel) begin
            MUX_MODE_O <= strap_s2_r;                            // [RL9]
        end
    end

    // Cycle framing: separate mode opens on select fall, mux on strobe fall under select.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (!MUX_MODE_O && cs_fall) state_nxt = ST_SEP;
                else if (MUX_MODE_O && !cs_n_s && ale_fall) state_nxt = ST_MUX;
            end
            ST_SEP:  if (cs_rise) state_nxt = ST_IDLE;
            ST_MUX:  if (cs_rise) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_r       <= ST_IDLE;
            WORD_ADDR_O   <= '0;
            ADDR_VALID_O  <= 1'b0;
            CYCLE_WRITE_O <= 1'b0;
            CYCLE_END_O   <= 1'b0;
            DATA_OE_O     <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            CYCLE_END_O <= cs_rise && (state_r != ST_IDLE);      // [RL5]
            if (state_r == ST_IDLE && state_nxt == ST_SEP) begin
                WORD_ADDR_O  <= sep_addr;                        // [RL1]
                ADDR_VALID_O <= 1'b1;
            end else if (state_r == ST_IDLE && state_nxt == ST_MUX) begin
                WORD_ADDR_O  <= mux_addr;
                ADDR_VALID_O <= 1'b1;
            end else if (cs_rise) begin
                ADDR_VALID_O <= 1'b0;
            end
            CYCLE_WRITE_O <= ~we_n_s & ~cs_n_s;
            DATA_OE_O     <= ~oe_n_s & ~cs_n_s & we_n_s;         // [RL11]
        end
    end

    // Interrupt and wave outputs, each interrupt an OR of its chosen events.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            IRQ_OUT_ZERO_O <= 1'b0;
            IRQ_OUT_ONE_O  <= 1'b0;
            IRQ_OUT_TWO_O  <= 1'b0;
            SYNC_WAVE_OUT_SIX_O   <= 1'b0;
            SYNC_WAVE_OUT_SEVEN_O <= 1'b0;
        end else begin
            IRQ_OUT_ZERO_O <= irq0_req;                          // [RL6]
            IRQ_OUT_ONE_O  <= irq1_req;
            IRQ_OUT_TWO_O  <= irq2_req;
            SYNC_WAVE_OUT_SIX_O   <= wave6;                      // [RL7]
            SYNC_WAVE_OUT_SEVEN_O <= wave7;
        end
    end

    sync_wave_gen #(.W(WW)) u_wave6 (
        .clk_i  (CLK_I),
        .rst_i  (RST_I),
        .tick_i (TB_TICK_I),
        .half_i (WAVE_HALF_SIX_I),
        .wave_o (wave6)
    );
    sync_wave_gen #(.W(WW)) u_wave7 (
        .clk_i  (CLK_I),
        .rst_i  (RST_I),
        .tick_i (TB_TICK_I),
        .half_i (WAVE_HALF_SEVEN_I),
        .wave_o (wave7)
    );

    // Checks.
    property p_sep_latch;
        @(posedge CLK_I) disable iff (RST_I)
        (!MUX_MODE_O && state_r == ST_IDLE && cs_fall) |=>
            (ADDR_VALID_O && WORD_ADDR_O == $past(sep_addr));
    endproperty
    a_sep_latch: assert property (p_sep_latch) else $error("address not latched"); // [RL1]
    property p_word_align;
        @(posedge CLK_I) disable iff (RST_I) WORD_ADDR_O[1:0] == 2'b00;
    endproperty
    a_word_align: assert property (p_word_align) else $error("address not word aligned"); // [RL2]
    property p_mux_strobe;
        @(posedge CLK_I) disable iff (RST_I)
        (MUX_MODE_O && state_r == ST_IDLE && !cs_n_s && ale_fall) |=> state_r == ST_MUX;
    endproperty
    a_mux_strobe: assert property (p_mux_strobe) else $error("strobe ignored"); // [RL3]
    property p_mux_no_sep;
        @(posedge CLK_I) disable iff (RST_I) MUX_MODE_O |-> state_r != ST_SEP;
    endproperty
    a_mux_no_sep: assert property (p_mux_no_sep) else $error("separate cycle in mux"); // [RL4]
    property p_cs_end;
        @(posedge CLK_I) disable iff (RST_I)
        (cs_rise && state_r != ST_IDLE) |=> (CYCLE_END_O && !ADDR_VALID_O && state_r == ST_IDLE);
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("cycle not ended"); // [RL5]
    property p_irq;
        @(posedge CLK_I) disable iff (RST_I)
        !$past(RST_I) |-> IRQ_OUT_ONE_O == $past(irq1_req);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch"); // [RL6]
    property p_wave_tick;
        @(posedge CLK_I) disable iff (RST_I)
        (!$past(TB_TICK_I, 2) && !$past(RST_I, 2) && !$past(RST_I)) |->
            $stable(SYNC_WAVE_OUT_SIX_O);
    endproperty
    a_wave_tick: assert property (p_wave_tick) else $error("wave moved off tick"); // [RL7]
    property p_strap;
        @(posedge CLK_I) $fell(RST_I) ##1 1'b1 |-> MUX_MODE_O == $past(strap_s2_r);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not captured"); // [RL9]
    property p_oe;
        @(posedge CLK_I) disable iff (RST_I) DATA_OE_O |-> !$past(oe_n_s);
    endproperty
    a_oe: assert property (p_oe) else $error("drive without output enable"); // [RL11]
    c_sep: cover property (@(posedge CLK_I) state_r == ST_SEP ##[1:20] CYCLE_END_O);
    c_mux: cover property (@(posedge CLK_I) state_r == ST_MUX ##[1:20] CYCLE_END_O);
    c_oe:  cover property (@(posedge CLK_I) DATA_OE_O);
endmodule : host_bus_address_capture
`default_nettype wire

// [rtl/host_bus_address_capture_map.svh]
// Constants for the host bus address capture block.
`ifndef HOST_BUS_ADDRESS_CAPTURE_MAP_SVH
`define HOST_BUS_ADDRESS_CAPTURE_MAP_SVH
`define HBA_ADDR_W        6
`define HBA_ADDR_LSB      2
`define HBA_IRQ_NUM       3
`define HBA_EVT_W         8
`define HBA_WAVE_W        16
`define HBA_WAVE_HALF_RST 16'h0004
`define HBA_MUX_RST       1'b0
`endif

// [rtl/host_bus_address_capture_pkg.sv]
// Types for the host bus address capture block.
package host_bus_address_capture_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEP  = 3'b010,
        ST_MUX  = 3'b100
    } cycle_state_t;
endpackage : host_bus_address_capture_pkg

// [rtl/sync_wave_gen.sv]
// Square-wave generator locked to the internal time base tick.
`timescale 1ns/1ps
`default_nettype none
module sync_wave_gen #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] half_i,
    output logic              wave_o
);
    logic [W-1:0] cnt_r;

    // Toggle every half period of time base ticks, so edges stay on tick boundaries.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            wave_o <= 1'b0;
        end else if (tick_i) begin
            if (cnt_r + W'(1) >= half_i) begin
                cnt_r  <= '0;
                wave_o <= ~wave_o;
            end else begin
                cnt_r <= cnt_r + W'(1);
            end
        end
    end
endmodule : sync_wave_gen
`default_nettype wire

// [testbench/host_model.sv]
// Host processor model that drives the parallel bus pins.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic  clk_i,
    output logic       cs_n_o,
    output logic       we_n_o,
    output logic       oe_n_o,
    output logic [5:0] addr_o,
    output logic [5:0] mux_addr_o
);
    // The bus starts idle, deselected and reading.
    initial begin
        cs_n_o = 1'b1;
        we_n_o = 1'b1;
        oe_n_o = 1'b1;
        addr_o = 6'h00;
        mux_addr_o = 6'h00;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    // Address and direction settle well before select falls, so capture cannot race.
    task automatic open(input logic [5:0] a, input logic wr);
        @(posedge clk_i);
        addr_o <= a;
        we_n_o <= ~wr;
        cyc(3);
        cs_n_o <= 1'b0;
        oe_n_o <= 1'b0;
    endtask : open
    // Released lines show the inverse so a stale value is never mistaken for a held one.
    task automatic close();
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        oe_n_o <= 1'b1;
        addr_o <= ~addr_o;
    endtask : close
    task automatic drive_addr(input logic [5:0] a);
        @(posedge clk_i);
        addr_o <= a;
    endtask : drive_addr
    // Strobe pulse on the bit-2 pin with the address on the shared lines.
    task automatic latch_mux(input logic [5:0] ma);
        @(posedge clk_i);
        addr_o[0] <= 1'b1;
        mux_addr_o <= ma;
        cyc(3);
        addr_o[0] <= 1'b0;
        cyc(3);
        mux_addr_o <= ~ma;
    endtask : latch_mux
endmodule : host_model
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking testbench for the host bus address capture block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst, strap, tick;
    logic cs_n, we_n, oe_n, valid, wr, cend, doe, mmode, q0, q1, q2, w6, w7;
    logic [5:0] addr, maddr;
    logic [7:0] ev, s0, s1, s2, waddr;
    logic [15:0] h6, h7;
    int failures = 0, compares = 0;
    // Clock at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    host_model host (.clk_i(clk), .cs_n_o(cs_n), .we_n_o(we_n), .oe_n_o(oe_n),
        .addr_o(addr), .mux_addr_o(maddr));
    host_bus_address_capture dut (.CLK_I(clk), .RST_I(rst), .BUS_MUX_STRAP_I(strap),
        .CS_N_I(cs_n), .WE_N_I(we_n), .OE_N_I(oe_n), .ADDR_LINES_I(addr),
        .MUX_ADDR_I(maddr), .EVENTS_I(ev), .IRQ_SEL_ZERO_I(s0), .IRQ_SEL_ONE_I(s1),
        .IRQ_SEL_TWO_I(s2), .TB_TICK_I(tick), .WAVE_HALF_SIX_I(h6),
        .WAVE_HALF_SEVEN_I(h7), .WORD_ADDR_O(waddr), .ADDR_VALID_O(valid),
        .CYCLE_WRITE_O(wr), .CYCLE_END_O(cend), .DATA_OE_O(doe), .MUX_MODE_O(mmode),
        .IRQ_OUT_ZERO_O(q0), .IRQ_OUT_ONE_O(q1), .IRQ_OUT_TWO_O(q2),
        .SYNC_WAVE_OUT_SIX_O(w6), .SYNC_WAVE_OUT_SEVEN_O(w7));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Reset with the strap held, then let the strap synchroniser settle.
    task automatic do_reset(input logic s);
        @(posedge clk);
        strap <= s;
        rst <= 1'b1;
        host.cyc(6);
        rst <= 1'b0;
        host.cyc(4);
        chk(mmode, s);
    endtask : do_reset
    // Bounded wait for the end pulse; the valid flag must drop with it.
    task automatic wait_end();
        int n;
        n = 0;
        while (cend !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1 n++;
        end
        chk(cend, 1'b1);
        chk(valid, 1'b0);
        host.cyc(3);
    endtask : wait_end
    task automatic t_sep_read();
        host.open(6'h2D, 1'b0);
        host.cyc(2);
        host.drive_addr(6'h12);
        host.cyc(5);
        #1 chk(waddr, 8'hB4);
        chk({valid, wr, doe}, 8'h05);
        host.close();
        wait_end();
        $display("test sep_read done");
    endtask : t_sep_read
    task automatic t_sep_write();
        host.open(6'h01, 1'b1);
        host.cyc(5);
        #1 chk(waddr, 8'h04);
        chk({valid, wr, doe}, 8'h06);
        host.close();
        wait_end();
        $display("test sep_write done");
    endtask : t_sep_write
    task automatic t_irq();
        @(posedge clk);
        ev <= 8'h05;
        host.cyc(4);
        #1 chk({q0, q1, q2}, 8'h05);
        @(posedge clk);
        ev <= 8'h80;
        host.cyc(4);
        #1 chk({q0, q1, q2}, 8'h01);
        // New selects move the same event onto the other two outputs.
        @(posedge clk);
        s0 <= 8'h80;
        s1 <= 8'h80;
        s2 <= 8'h03;
        host.cyc(4);
        #1 chk({q0, q1, q2}, 8'h06);
        $display("test irq done");
    endtask : t_irq
    // Each half period of ticks toggles a wave; without ticks it must hold.
    // Eighteen ticks are sent; two idle edges let the last toggle reach the pins.
    task automatic t_wave(input logic [15:0] a6, input logic [15:0] a7,
                          input logic [7:0] e6, input logic [7:0] e7);
        int n6, n7;
        logic p6, p7;
        n6 = 0;
        n7 = 0;
        @(posedge clk);
        h6 <= a6;
        h7 <= a7;
        p6 = w6;
        p7 = w7;
        for (int i = 0; i < 38; i++) begin
            @(posedge clk);
            tick <= ~tick & (i < 36);
            #1 n6 += (w6 !== p6);
            n7 += (w7 !== p7);
            p6 = w6;
            p7 = w7;
        end
        chk(n6[7:0], e6);
        chk(n7[7:0], e7);
        $display("test wave done");
    endtask : t_wave
    task automatic t_mux();
        do_reset(1'b1);
        host.open(6'h0A, 1'b0);
        host.latch_mux(6'h2A);
        host.cyc(2);
        #1 chk(waddr, 8'hA8);
        chk(valid, 1'b1);
        host.close();
        wait_end();
        $display("test mux done");
    endtask : t_mux
    task automatic finish_test();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        rst = 1'b1;
        strap = 1'b0;
        tick = 1'b0;
        ev = 8'h00;
        s0 = 8'h01;
        s1 = 8'h02;
        s2 = 8'h84;
        h6 = 16'h0002;
        h7 = 16'h0003;
        do_reset(1'b0);
        t_sep_read();
        t_sep_write();
        t_irq();
        t_wave(16'h0002, 16'h0003, 8'h09, 8'h06);
        t_wave(16'h0003, 16'h0002, 8'h06, 8'h09);
        t_mux();
        finish_test();
    end
    // Watchdog well beyond the 170 or so cycles the tests need.
    initial begin
        #300000;
        failures++;
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
